// [design/fspc_defines.vh]
// Constants for the fast system call and privilege check block.
// Assumes inclusion by bare name, with this folder on the include path for design and bench files.
`ifndef FSPC_DEFINES_VH
`define FSPC_DEFINES_VH
// Opcodes on op_i
`define FSPC_OP_NONE      4'h0
`define FSPC_OP_ENTRY     4'h1
`define FSPC_OP_RETURN    4'h2
`define FSPC_OP_PRIV      4'h3
`define FSPC_OP_PERF_RD   4'h4
`define FSPC_OP_TS_RD     4'h5
`define FSPC_OP_MSR_WR    4'h6
`define FSPC_OP_MSR_RD    4'h7
`define FSPC_OP_ACC_RT    4'h8
`define FSPC_OP_VER_RD    4'h9
`define FSPC_OP_VER_WR    4'ha
`define FSPC_OP_FAR_CALL  4'hb
`define FSPC_OP_FEAT_ID   4'hc
// Model register select on msr_sel_i
`define FSPC_MSR_SEL_BASE 2'h0
`define FSPC_MSR_SEL_TGT  2'h1
`define FSPC_MSR_SEL_MASK 2'h2
// Selector fields and adds
`define FSPC_ENTRY_CS_HI  47
`define FSPC_ENTRY_CS_LO  32
`define FSPC_RET_CS_HI    63
`define FSPC_RET_CS_LO    48
`define FSPC_SS_ADD       16'h0008
`define FSPC_RET64_CS_ADD 16'h0010
// Control register four bits
`define FSPC_CTRL4_PERF_BIT 4
`define FSPC_CTRL4_TS_BIT   2
// Feature result bit
`define FSPC_FEAT_BIT     11
// Access rights mask on second doubleword
`define FSPC_ACC_MASK     32'h00ffff00
// Canonical width
`define FSPC_VA_BITS      48
// Reset values
`define FSPC_MSR_RST      64'h0000000000000000
`endif

// [design/fspc_desc_check.v]
// Descriptor check for access-rights, read and write verify, far call.
// Assumes the descriptor high dword is fetched by the caller.
`timescale 1ns/1ns
`default_nettype none
module fspc_desc_check (
  input  wire [15:0] sel_i,
  input  wire [31:0] desc_hi_i,
  input  wire        in_limit_i,
  input  wire [1:0]  current_privilege_level_i,
  input  wire [1:0]  kind_i,
  output reg         pass_o
);
  // kind_i: 0 access rights, 1 verify read, 2 verify write, 3 far call
  wire       s_bit  = desc_hi_i[12];
  wire [3:0] typ    = desc_hi_i[11:8];
  wire [1:0] desc_lvl = desc_hi_i[14:13];
  wire [1:0] req_lvl  = sel_i[1:0];
  wire       code   = s_bit & typ[3];
  wire       conf   = code & typ[2];
  wire       null_s = (sel_i[15:2] == 14'h0000);
  wire       visible = conf | ((current_privilege_level_i <= desc_lvl) & (req_lvl <= desc_lvl));
  reg        type_ok;
  always @* begin
    type_ok = 1'b0;
    pass_o  = 1'b0;
    case (kind_i)
      2'h0: begin
        // Code, data, local table, call gate, task gate, task state seg
        type_ok = s_bit | (typ == 4'h2) | (typ == 4'h1) | (typ == 4'h3) |
                  (typ == 4'h9) | (typ == 4'hb) | (typ == 4'hc) |
                  (typ == 4'h5) | (typ == 4'h4);
        pass_o  = ~null_s & in_limit_i & type_ok & visible;
      end
      2'h1: begin
        type_ok = s_bit & (~typ[3] | typ[1]);
        pass_o  = ~null_s & in_limit_i & type_ok & visible;
      end
      2'h2: begin
        // Code segments are never writable
        type_ok = s_bit & ~typ[3] & typ[1];
        pass_o  = ~null_s & in_limit_i & type_ok & visible;
      end
      default: begin
        // Gate and task state types only count on system descriptors, never on data
        type_ok = code | (~s_bit & ((typ == 4'hc) | (typ == 4'h5) | (typ == 4'h9) |
                  (typ == 4'hb) | (typ == 4'h1) | (typ == 4'h3) | (typ == 4'h4)));
        pass_o  = ~null_s & in_limit_i & type_ok &
                  (~code | conf | ((desc_lvl == current_privilege_level_i) &
                  (req_lvl <= desc_lvl)));
      end
    endcase
  end
endmodule
`default_nettype wire

// [design/fspc_top.v]
// Privilege control: fast system entry/return targets, privileged faults,
// descriptor checks. Assumes one op per cycle, held valid for one cycle.
// What this block does
// - Entry copies entry instruction pointer into return-pointer register.
// - Entry code selector from selector register [47:32]; stack selector plus 8.
// - Entry loads instruction pointer from the long entry target register.
// - Entry saves flags, low 32 bits ANDed with complemented flag mask.
// - Wide return: code selector field [63:48]+16, stack +8, pointer and flags restored.
// - 32-bit return: code selector field, stack +8, low pointer, flags restored.
// - Entry and return are refused in compatibility mode.
// - Feature result bit 11 reads one when entry and return exist.
// - Non-canonical write to entry target register faults.
// - Privileged instructions fault outside level 0.
// - Privileged set covers table loads, register moves, cache, halt, counters.
// - Control register four bits 4 and 2 open counter and time reads.
// - Type, rights and limit checked automatically; alignment only at level 3.
// - Far call target type and nonconforming level checks, else fault.
// - Access-rights op checks null, limit, type and visibility.
// - Access-rights pass writes masked high dword and sets zero flag.
// - Verify ops check null, limit, code or data type, visibility.
// - Verify sets zero flag when visible and readable or writable.
`timescale 1ns/1ns
`default_nettype none
`include "fspc_defines.vh"
module fspc_top (
  input  wire        clk_sys_i,
  input  wire        srst_i,
  input  wire        op_valid_i,
  input  wire [3:0]  op_i,
  input  wire [1:0]  current_privilege_level_i,
  input  wire        compat_mode_i,
  input  wire        wide_operand_prefix_i,
  input  wire        align_check_en_i,
  input  wire [31:0] control_register_four_i,
  input  wire [63:0] rip_i,
  input  wire [63:0] flags_register_wide_i,
  input  wire [63:0] return_pointer_gpr_i,
  input  wire [63:0] saved_flags_gpr_i,
  input  wire [1:0]  msr_sel_i,
  input  wire [63:0] msr_wdata_i,
  input  wire [15:0] sel_i,
  input  wire [31:0] desc_hi_i,
  input  wire        desc_in_limit_i,
  input  wire [31:0] dest_i,
  output reg         done_o,
  output reg         general_protection_fault_o,
  output reg         redirect_o,
  output reg  [63:0] new_rip_o,
  output reg  [15:0] new_cs_o,
  output reg  [15:0] new_ss_o,
  output reg  [1:0]  new_privilege_level_o,
  output reg         new_long_o,
  output reg  [63:0] flags_out_o,
  output reg         flags_we_o,
  output reg  [63:0] return_pointer_gpr_o,
  output reg         return_pointer_we_o,
  output reg  [63:0] saved_flags_gpr_o,
  output reg         saved_flags_we_o,
  output reg  [31:0] dest_o,
  output reg         dest_we_o,
  output reg         zero_flag_o,
  output reg         zero_flag_we_o,
  output reg  [63:0] msr_rdata_o,
  output reg  [31:0] feat_edx_o,
  output reg         align_check_active_o
);
  reg  [63:0] fast_system_entry_selector_base_q;
  reg  [63:0] long_entry_target_q;
  reg  [63:0] entry_flag_mask_q;
  reg  [1:0]  kind;
  wire        desc_pass;
  fspc_desc_check u_check (
    .sel_i      (sel_i),
    .desc_hi_i  (desc_hi_i),
    .in_limit_i (desc_in_limit_i),
    .current_privilege_level_i (current_privilege_level_i),
    .kind_i     (kind),
    .pass_o     (desc_pass)
  );
  always @* begin
    case (op_i)
      `FSPC_OP_ACC_RT: kind = 2'h0;
      `FSPC_OP_VER_RD: kind = 2'h1;
      `FSPC_OP_VER_WR: kind = 2'h2;
      default:         kind = 2'h3;
    endcase
  end
  // Canonical: bits 63 down to the top address bit all equal
  wire [63:0] wd = msr_wdata_i;
  wire canon = (wd[63:`FSPC_VA_BITS-1] == {(65-`FSPC_VA_BITS){1'b0}}) |
               (wd[63:`FSPC_VA_BITS-1] == {(65-`FSPC_VA_BITS){1'b1}});
  wire is_l0    = (current_privilege_level_i == 2'h0);
  wire perf_any = control_register_four_i[`FSPC_CTRL4_PERF_BIT];
  wire ts_any   = control_register_four_i[`FSPC_CTRL4_TS_BIT];
  wire [15:0] entry_cs = fast_system_entry_selector_base_q[`FSPC_ENTRY_CS_HI:`FSPC_ENTRY_CS_LO];
  wire [15:0] ret_cs   = fast_system_entry_selector_base_q[`FSPC_RET_CS_HI:`FSPC_RET_CS_LO];
  reg fault;
  always @* begin
    fault = 1'b0;
    case (op_i)
      `FSPC_OP_ENTRY:    fault = compat_mode_i | (entry_cs[15:2] == 14'h0000);
      `FSPC_OP_RETURN:   fault = compat_mode_i | ~is_l0;
      `FSPC_OP_PRIV:     fault = ~is_l0;
      `FSPC_OP_MSR_RD:   fault = ~is_l0;
      `FSPC_OP_MSR_WR:   fault = ~is_l0 |
                                 ((msr_sel_i == `FSPC_MSR_SEL_TGT) & ~canon);
      `FSPC_OP_PERF_RD:  fault = ~is_l0 & ~perf_any;
      `FSPC_OP_TS_RD:    fault = ~is_l0 & ~ts_any;
      `FSPC_OP_FAR_CALL: fault = ~desc_pass;
      default:           fault = 1'b0;
    endcase
  end
  wire go = op_valid_i & ~srst_i;
  always @(posedge clk_sys_i) begin
    if (srst_i) begin
      fast_system_entry_selector_base_q    <= `FSPC_MSR_RST;
      long_entry_target_q        <= `FSPC_MSR_RST;
      entry_flag_mask_q          <= `FSPC_MSR_RST;
      done_o                     <= 1'b0;
      general_protection_fault_o <= 1'b0;
      redirect_o                 <= 1'b0;
      new_rip_o                  <= 64'h0;
      new_cs_o                   <= 16'h0;
      new_ss_o                   <= 16'h0;
      new_privilege_level_o      <= 2'h0;
      new_long_o                 <= 1'b0;
      flags_out_o                <= 64'h0;
      flags_we_o                 <= 1'b0;
      return_pointer_gpr_o       <= 64'h0;
      return_pointer_we_o        <= 1'b0;
      saved_flags_gpr_o          <= 64'h0;
      saved_flags_we_o           <= 1'b0;
      dest_o                     <= 32'h0;
      dest_we_o                  <= 1'b0;
      zero_flag_o                <= 1'b0;
      zero_flag_we_o             <= 1'b0;
      msr_rdata_o                <= 64'h0;
      feat_edx_o                 <= 32'h0;
      align_check_active_o       <= 1'b0;
    end else begin
      done_o                     <= go;
      general_protection_fault_o <= go & fault;
      redirect_o                 <= 1'b0;
      flags_we_o                 <= 1'b0;
      return_pointer_we_o        <= 1'b0;
      saved_flags_we_o           <= 1'b0;
      dest_we_o                  <= 1'b0;
      zero_flag_we_o             <= 1'b0;
      // Alignment faults are raised elsewhere; only the level gate lives here
      align_check_active_o       <= align_check_en_i & (current_privilege_level_i == 2'h3);
      if (go & ~fault) begin
        case (op_i)
          `FSPC_OP_ENTRY: begin
            return_pointer_gpr_o <= rip_i;
            return_pointer_we_o  <= 1'b1;
            saved_flags_gpr_o    <= flags_register_wide_i;
            saved_flags_we_o     <= 1'b1;
            flags_out_o <= {flags_register_wide_i[63:32],
                            flags_register_wide_i[31:0] & ~entry_flag_mask_q[31:0]};
            flags_we_o  <= 1'b1;
            new_cs_o    <= entry_cs;
            new_ss_o    <= entry_cs + `FSPC_SS_ADD;
            new_rip_o   <= long_entry_target_q;
            new_privilege_level_o <= 2'h0;
            new_long_o  <= 1'b1;
            redirect_o  <= 1'b1;
          end
          `FSPC_OP_RETURN: begin
            new_ss_o    <= ret_cs + `FSPC_SS_ADD;
            flags_out_o <= saved_flags_gpr_i;
            flags_we_o  <= 1'b1;
            new_privilege_level_o <= 2'h3;
            redirect_o  <= 1'b1;
            if (wide_operand_prefix_i) begin
              new_cs_o   <= ret_cs + `FSPC_RET64_CS_ADD;
              new_rip_o  <= return_pointer_gpr_i;
              new_long_o <= 1'b1;
            end else begin
              new_cs_o   <= ret_cs;
              new_rip_o  <= {32'h0, return_pointer_gpr_i[31:0]};
              new_long_o <= 1'b0;
            end
          end
          `FSPC_OP_MSR_WR: begin
            case (msr_sel_i)
              `FSPC_MSR_SEL_BASE: fast_system_entry_selector_base_q <= msr_wdata_i;
              `FSPC_MSR_SEL_TGT:  long_entry_target_q     <= msr_wdata_i;
              `FSPC_MSR_SEL_MASK: entry_flag_mask_q       <= msr_wdata_i;
              default: ;
            endcase
          end
          `FSPC_OP_MSR_RD: begin
            case (msr_sel_i)
              `FSPC_MSR_SEL_BASE: msr_rdata_o <= fast_system_entry_selector_base_q;
              `FSPC_MSR_SEL_TGT:  msr_rdata_o <= long_entry_target_q;
              `FSPC_MSR_SEL_MASK: msr_rdata_o <= entry_flag_mask_q;
              default:            msr_rdata_o <= 64'h0;
            endcase
          end
          `FSPC_OP_FEAT_ID: begin
            feat_edx_o <= 32'h1 << `FSPC_FEAT_BIT;
          end
          `FSPC_OP_ACC_RT: begin
            zero_flag_o    <= desc_pass;
            zero_flag_we_o <= 1'b1;
            dest_we_o      <= desc_pass;
            dest_o         <= desc_pass ? (desc_hi_i & `FSPC_ACC_MASK) : dest_i;
          end
          `FSPC_OP_VER_RD, `FSPC_OP_VER_WR: begin
            zero_flag_o    <= desc_pass;
            zero_flag_we_o <= 1'b1;
          end
          default: ;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// [bench/fspc_top_assertions.sv]
// Checker for the privilege control block: timing and result relations.
// Assumes it is bound to fspc_top and sees only that module's ports.
`timescale 1ns/1ns
`default_nettype none
`include "fspc_defines.vh"
module fspc_top_assertions (
  input wire logic        clk_sys_i,
  input wire logic        srst_i,
  input wire logic        op_valid_i,
  input wire logic [3:0]  op_i,
  input wire logic [1:0]  current_privilege_level_i,
  input wire logic        compat_mode_i,
  input wire logic        align_check_en_i,
  input wire logic [31:0] control_register_four_i,
  input wire logic [63:0] rip_i,
  input wire logic        done_o,
  input wire logic        general_protection_fault_o,
  input wire logic        redirect_o,
  input wire logic [15:0] new_cs_o,
  input wire logic [15:0] new_ss_o,
  input wire logic [63:0] return_pointer_gpr_o,
  input wire logic        return_pointer_we_o,
  input wire logic [31:0] dest_o,
  input wire logic        dest_we_o,
  input wire logic        zero_flag_o,
  input wire logic        align_check_active_o
);
  logic [1:0] lvl_q;
  logic       perf_q;
  logic       en_q;
  logic       rst_q;
  // Own copies of the inputs one edge back, so no sampled function sees reset values
  always @(posedge clk_sys_i) begin
    lvl_q <= current_privilege_level_i;
    perf_q <= control_register_four_i[`FSPC_CTRL4_PERF_BIT];
    en_q <= align_check_en_i;
    rst_q <= srst_i;
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);
  property p_done;
    op_valid_i |=> done_o;
  endproperty
  a_done: assert property (p_done) else $error("Operation not answered");
  property p_quiet;
    general_protection_fault_o |-> done_o && !redirect_o && !return_pointer_we_o && !dest_we_o;
  endproperty
  a_quiet: assert property (p_quiet) else $error("Fault with side effects");
  property p_priv;
    op_valid_i && op_i == `FSPC_OP_PRIV |=> general_protection_fault_o == (lvl_q != 2'h0);
  endproperty
  a_priv: assert property (p_priv) else $error("Privileged fault wrong");
  property p_perf;
    op_valid_i && op_i == `FSPC_OP_PERF_RD |=>
      general_protection_fault_o == (lvl_q != 2'h0 && !perf_q);
  endproperty
  a_perf: assert property (p_perf) else $error("Counter read fault wrong");
  property p_entry;
    op_valid_i && op_i == `FSPC_OP_ENTRY && !compat_mode_i |=> general_protection_fault_o ||
      (redirect_o && return_pointer_gpr_o == $past(rip_i) && new_ss_o == new_cs_o + 16'h0008);
  endproperty
  a_entry: assert property (p_entry) else $error("Entry targets wrong");
  property p_compat;
    op_valid_i && compat_mode_i && (op_i == `FSPC_OP_ENTRY || op_i == `FSPC_OP_RETURN)
      |=> general_protection_fault_o && !redirect_o;
  endproperty
  a_compat: assert property (p_compat) else $error("Compat mode not refused");
  property p_acc;
    dest_we_o |-> zero_flag_o && (dest_o & ~`FSPC_ACC_MASK) == 32'h0;
  endproperty
  a_acc: assert property (p_acc) else $error("Access rights result wrong");
  property p_align;
    !rst_q |-> align_check_active_o == (en_q && lvl_q == 2'h3);
  endproperty
  a_align: assert property (p_align) else $error("Alignment level wrong");
  c_entry: cover property (op_valid_i && op_i == `FSPC_OP_ENTRY ##1 redirect_o);
  c_fault: cover property (general_protection_fault_o);
  c_dest: cover property (dest_we_o);
endmodule
bind fspc_top fspc_top_assertions i_fspc_top_assertions (.*);
`default_nettype wire

// [bench/fspc_top_bench.sv]
// Self-checking bench for the privilege control block, random ops against a model.
// Assumes fspc_top, its checker and the defines header are on the compile path.
`timescale 1ns/1ns
`default_nettype none
`include "fspc_defines.vh"
module fspc_top_bench;
  logic        clk_sys_i = 1'h0, srst_i = 1'h1, op_valid_i = 1'h0, compat_mode_i = 1'h0;
  logic        wide_operand_prefix_i = 1'h0, align_check_en_i = 1'h0, desc_in_limit_i = 1'h0;
  logic [3:0]  op_i = 4'h0, c;
  logic [1:0]  current_privilege_level_i = 2'h0, msr_sel_i = 2'h0, new_privilege_level_o;
  logic [15:0] sel_i = 16'h0, new_cs_o, new_ss_o;
  logic [31:0] control_register_four_i = 32'h0, desc_hi_i = 32'h0, dest_i = 32'h0;
  logic [63:0] rip_i = 64'h0, flags_register_wide_i = 64'h0, return_pointer_gpr_i = 64'h0;
  logic [63:0] saved_flags_gpr_i = 64'h0, msr_wdata_i = 64'h0;
  logic        done_o, general_protection_fault_o, redirect_o, new_long_o, flags_we_o;
  logic        return_pointer_we_o, saved_flags_we_o, dest_we_o, zero_flag_o, zero_flag_we_o;
  logic        align_check_active_o, f, p;
  logic [31:0] dest_o, feat_edx_o;
  logic [63:0] new_rip_o, flags_out_o, return_pointer_gpr_o, saved_flags_gpr_o, msr_rdata_o;
  logic [63:0] msr_m [0:2];
  integer      seed = 71639, errors = 0, cmp_count = 0, cyc = 0;
  fspc_top i_fspc_top (.*);
  always #50 clk_sys_i = ~clk_sys_i;
  task automatic end_sim;
    $display("Comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      errors = errors + 1;
      end_sim;
    end
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count = cmp_count + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Inputs are set at a falling edge; results are read one falling edge later
  task automatic issue(input logic [3:0] code);
    op_i = code;
    op_valid_i = 1'h1;
    @(negedge clk_sys_i);
  endtask
  // Descriptor checks: 0 access rights, 1 read verify, 2 write verify, 3 far call
  function automatic logic dpass(input logic [1:0] k);
    logic [3:0] t;
    logic [1:0] lvl;
    logic       code, conf, vis;
    t = desc_hi_i[11:8];
    lvl = desc_hi_i[14:13];
    code = desc_hi_i[12] & t[3];
    conf = code & t[2];
    vis = conf || (current_privilege_level_i <= lvl && sel_i[1:0] <= lvl);
    if (sel_i[15:2] == 14'h0 || !desc_in_limit_i)
      return 1'h0;
    case (k)
      2'h0: return vis && (desc_hi_i[12] || t inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h9,
                                                      4'hb, 4'hc});
      2'h1: return vis && desc_hi_i[12] && (!code || t[1]);
      2'h2: return vis && desc_hi_i[12] && !code && t[1];
      default: return (code && (conf || (lvl == current_privilege_level_i &&
                                         sel_i[1:0] <= lvl))) ||
                      (!desc_hi_i[12] && t inside {4'h1, 4'h3, 4'h4, 4'h5, 4'h9, 4'hb, 4'hc});
    endcase
  endfunction
  initial begin
    msr_m = '{default: 64'h0};
    repeat (16) @(negedge clk_sys_i);
    srst_i = 1'h0;
    for (int i = 0; i < 3; i++) begin
      msr_sel_i = i[1:0];
      issue(`FSPC_OP_MSR_RD);
      chk(msr_rdata_o, 64'h0);
    end
    $display("reset test done");
    repeat (400) begin
      c = 4'($random(seed));
      current_privilege_level_i = 2'($random(seed));
      compat_mode_i = ($random(seed) % 4) == 0;
      {wide_operand_prefix_i, align_check_en_i, msr_sel_i} = 4'($random(seed));
      if (msr_sel_i == 2'h3)
        msr_sel_i = `FSPC_MSR_SEL_BASE;
      control_register_four_i = $random(seed);
      rip_i = {$random(seed), $random(seed)};
      flags_register_wide_i = {$random(seed), $random(seed)};
      return_pointer_gpr_i = {$random(seed), $random(seed)};
      saved_flags_gpr_i = {$random(seed), $random(seed)};
      // Bit 40 keeps any written entry code selector index non-null, as system software would
      msr_wdata_i = {$random(seed), $random(seed)} | 64'h0000_0100_0000_0000;
      if (seed[0])
        msr_wdata_i[63:48] = {16{msr_wdata_i[47]}};
      sel_i = ($random(seed) % 8 == 0) ? 16'h0 : 16'($random(seed));
      desc_hi_i = $random(seed) | 32'h0000_8000;
      desc_in_limit_i = ($random(seed) % 8) != 0;
      dest_i = $random(seed);
      case (c)
        `FSPC_OP_ENTRY: f = compat_mode_i || msr_m[0][47:34] == 14'h0;
        `FSPC_OP_RETURN: f = compat_mode_i || current_privilege_level_i != 2'h0;
        `FSPC_OP_PRIV, `FSPC_OP_MSR_RD: f = current_privilege_level_i != 2'h0;
        `FSPC_OP_PERF_RD: f = current_privilege_level_i != 2'h0 &&
                              !control_register_four_i[`FSPC_CTRL4_PERF_BIT];
        `FSPC_OP_TS_RD: f = current_privilege_level_i != 2'h0 &&
                            !control_register_four_i[`FSPC_CTRL4_TS_BIT];
        `FSPC_OP_MSR_WR: f = current_privilege_level_i != 2'h0 ||
                             (msr_sel_i == `FSPC_MSR_SEL_TGT &&
                              msr_wdata_i[63:47] != {17{msr_wdata_i[47]}});
        `FSPC_OP_FAR_CALL: f = !dpass(2'h3);
        default: f = 1'h0;
      endcase
      issue(c);
      chk(done_o, 1'h1);
      chk(general_protection_fault_o, f);
      if (f) chk(redirect_o, 1'h0);
      chk(align_check_active_o, align_check_en_i && current_privilege_level_i == 2'h3);
      chk(zero_flag_we_o, !f && (c == `FSPC_OP_ACC_RT || c == `FSPC_OP_VER_RD ||
                                 c == `FSPC_OP_VER_WR));
      if (!f) case (c)
        `FSPC_OP_ENTRY: begin
          chk(return_pointer_gpr_o, rip_i);
          chk(redirect_o, 1'h1);
          chk(new_privilege_level_o, 2'h0);
          chk(new_long_o, 1'h1);
          chk({return_pointer_we_o, saved_flags_we_o, flags_we_o}, 3'h7);
          chk(new_cs_o, msr_m[0][47:32]);
          chk(new_ss_o, 16'(msr_m[0][47:32] + 16'h0008));
          chk(new_rip_o, msr_m[1]);
          chk(flags_out_o[31:0], flags_register_wide_i[31:0] & ~msr_m[2][31:0]);
          chk(saved_flags_gpr_o, flags_register_wide_i);
        end
        `FSPC_OP_RETURN: begin
          chk(new_cs_o, 16'(msr_m[0][63:48] + (wide_operand_prefix_i ? 16'h10 : 16'h0)));
          chk(new_ss_o, 16'(msr_m[0][63:48] + 16'h0008));
          chk(new_rip_o[31:0], return_pointer_gpr_i[31:0]);
          if (wide_operand_prefix_i) chk(new_rip_o, return_pointer_gpr_i);
          chk(redirect_o, 1'h1);
          chk(new_privilege_level_o, 2'h3);
          chk(new_long_o, wide_operand_prefix_i);
          chk(flags_out_o, saved_flags_gpr_i);
        end
        `FSPC_OP_MSR_WR: msr_m[msr_sel_i] = msr_wdata_i;
        `FSPC_OP_MSR_RD: chk(msr_rdata_o, msr_m[msr_sel_i]);
        `FSPC_OP_FEAT_ID: chk(feat_edx_o[11], 1'h1);
        `FSPC_OP_ACC_RT: begin
          p = dpass(2'h0);
          chk(zero_flag_o, p);
          chk(dest_we_o, p);
          if (p) chk(dest_o, desc_hi_i & `FSPC_ACC_MASK);
        end
        `FSPC_OP_VER_RD: chk(zero_flag_o, dpass(2'h1));
        `FSPC_OP_VER_WR: chk(zero_flag_o, dpass(2'h2));
        default: ;
      endcase
    end
    op_valid_i = 1'h0;
    $display("random test done");
    end_sim;
  end
endmodule
`default_nettype wire
